// ### rtl/cbe_consts.svh
// Purpose: offsets, field positions and reset values of the branch evaluator
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: included by bare name
`ifndef CBE_CONSTS_SVH
`define CBE_CONSTS_SVH

`define CBE_OFF_PC       8'h00
`define CBE_OFF_FLAGS    8'h04
`define CBE_OFF_CMD      8'h08
`define CBE_OFF_STAT     8'h0C

`define CBE_FLAG_C       0
`define CBE_FLAG_N       2
`define CBE_FLAG_V       3
`define CBE_FLAG_H       5

`define CBE_CMD_OP_LSB   0
`define CBE_CMD_OP_MSB   2
`define CBE_CMD_DISP_LSB 8
`define CBE_CMD_DISP_MSB 14

`define CBE_STAT_BUSY    0
`define CBE_STAT_TAKEN   1

`define CBE_PC_RST       16'h0000
`define CBE_DISP_RST     7'h00
`define CBE_PC_STEP      16'h0001
`define CBE_HSIZE_WORD   3'h2
`define CBE_HRESP_OKAY   1'h0

`endif

// ### rtl/cbe_pkg.sv
// Purpose: types shared by the branch evaluator files
// Assumes: nothing beyond SystemVerilog packages
// Notes: numeric constants live in cbe_consts.svh
package cbe_pkg;

	typedef enum logic [2:0] {
		CBE_OP_LOWER,
		CBE_OP_MINUS,
		CBE_OP_PLUS,
		CBE_OP_SGE,
		CBE_OP_SLT,
		CBE_OP_HSET,
		CBE_OP_HCLR,
		CBE_OP_NONE
	} cbe_op_e;

	typedef enum logic [1:0] {
		CBE_ST_IDLE,
		CBE_ST_EVAL,
		CBE_ST_TAKE
	} cbe_state_e;

	typedef struct packed {
		logic h;
		logic v;
		logic n;
		logic c;
	} cbe_flags_s;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} cbe_aphase_s;

endpackage

// ### rtl/cbe_cond.sv
// Purpose: decides whether a conditional branch is taken
// Assumes: flags are the live status values
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none

module cbe_cond
	import cbe_pkg::*;
(
	input  wire cbe_op_e    op,
	input  wire cbe_flags_s flags,
	output logic            take
);

	always_comb begin
		case (op)
			CBE_OP_LOWER: take = flags.c;
			CBE_OP_MINUS: take = flags.n;
			CBE_OP_PLUS:  take = ~flags.n;
			CBE_OP_SGE:   take = ~(flags.n ^ flags.v);
			CBE_OP_SLT:   take = flags.n ^ flags.v;
			CBE_OP_HSET:  take = flags.h;
			CBE_OP_HCLR:  take = ~flags.h;
			default:      take = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ### rtl/cbe_branch_top.sv
// Purpose: conditional relative-branch evaluator with an AHB-Lite register port
// Assumes: single word transfers, hsel selects this block's region
// Notes: a write to the command register while idle launches one branch; one made while busy is dropped
`timescale 1ns/10ps
`default_nettype none
`include "cbe_consts.svh"

// Operation
// - branch_if_lower is taken only when carry is 1, else it falls through.
// - branch_if_minus is taken only when negative is 1, else it falls through.
// - branch_if_plus is taken only when negative is 0, else it falls through.
// - branch_signed_greater_equal is taken only when negative xor overflow is 0.
// - branch_signed_less_than is taken only when negative xor overflow is 1.
// - branch_half_carry_set is taken only when half-carry is 1, else it falls through.
// - branch_half_carry_clear is taken only when half-carry is 0, else it falls through.
// - a taken branch loads the program counter with itself plus displacement plus one.
// - no branch alters a status flag, and each takes one or two cycles.
module cbe_branch_top
	import cbe_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [15:0] pc_value,
	output logic             branch_busy
);

	cbe_aphase_s aph_q;
	cbe_aphase_s aph_d;
	cbe_state_e  st_q;
	cbe_flags_s  flags_q;
	cbe_op_e     op_q;
	logic [6:0]  disp_q;
	logic [15:0] pc_q;
	logic        taken_q;
	logic [31:0] hrdata_q;

	wire logic        accept;
	wire logic        busy;
	wire logic        wr_pc;
	wire logic        wr_flags;
	wire logic        wr_cmd;
	wire logic        take;
	wire logic [15:0] disp_ext;
	wire logic [31:0] flags_word;
	wire logic [31:0] cmd_word;
	wire logic [31:0] stat_word;
	wire logic [31:0] rd_mux;

	// address phase capture
	assign accept = hsel & hready & htrans[1] & (hsize == `CBE_HSIZE_WORD);
	assign aph_d  = '{valid: accept, write: hwrite, addr: haddr[7:0]};

	assign busy     = (st_q != CBE_ST_IDLE);
	assign wr_pc    = aph_q.valid & aph_q.write & (aph_q.addr == `CBE_OFF_PC) & ~busy;
	assign wr_flags = aph_q.valid & aph_q.write & (aph_q.addr == `CBE_OFF_FLAGS);
	assign wr_cmd   = aph_q.valid & aph_q.write & (aph_q.addr == `CBE_OFF_CMD) & ~busy;

	assign disp_ext = {{9{disp_q[6]}}, disp_q};

	assign flags_word = (32'(flags_q.c) << `CBE_FLAG_C) | (32'(flags_q.n) << `CBE_FLAG_N)
		| (32'(flags_q.v) << `CBE_FLAG_V) | (32'(flags_q.h) << `CBE_FLAG_H);
	assign cmd_word  = (32'(op_q) << `CBE_CMD_OP_LSB) | (32'(disp_q) << `CBE_CMD_DISP_LSB);
	assign stat_word = (32'(busy) << `CBE_STAT_BUSY) | (32'(taken_q) << `CBE_STAT_TAKEN);

	assign rd_mux = (haddr[7:0] == `CBE_OFF_PC)    ? {16'h0000, pc_q} :
	                (haddr[7:0] == `CBE_OFF_FLAGS) ? flags_word :
	                (haddr[7:0] == `CBE_OFF_CMD)   ? cmd_word :
	                (haddr[7:0] == `CBE_OFF_STAT)  ? stat_word : 32'h00000000;

	// flags sampled straight from the status register
	cbe_cond u_cond (
		.op    (op_q),
		.flags (flags_q),
		.take  (take)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_q    <= '0;
			hrdata_q <= 32'h00000000;
		end else begin
			aph_q <= aph_d;
			if (accept && !hwrite) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	// only software writes the flags; branches never do
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= '0;
		end else if (wr_flags) begin
			flags_q.c <= hwdata[`CBE_FLAG_C];
			flags_q.n <= hwdata[`CBE_FLAG_N];
			flags_q.v <= hwdata[`CBE_FLAG_V];
			flags_q.h <= hwdata[`CBE_FLAG_H];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_q   <= CBE_OP_NONE;
			disp_q <= `CBE_DISP_RST;
		end else if (wr_cmd) begin
			op_q   <= cbe_op_e'(hwdata[`CBE_CMD_OP_MSB:`CBE_CMD_OP_LSB]);
			disp_q <= hwdata[`CBE_CMD_DISP_MSB:`CBE_CMD_DISP_LSB];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q    <= CBE_ST_IDLE;
			pc_q    <= `CBE_PC_RST;
			taken_q <= 1'b0;
		end else begin
			case (st_q)
				CBE_ST_IDLE: begin
					if (wr_pc) begin
						pc_q <= hwdata[15:0];
					end
					if (wr_cmd) begin
						st_q <= CBE_ST_EVAL;
					end
				end
				CBE_ST_EVAL: begin
					taken_q <= take;
					if (take) begin
						st_q <= CBE_ST_TAKE;
					end else begin
						pc_q <= pc_q + `CBE_PC_STEP;
						st_q <= CBE_ST_IDLE;
					end
				end
				CBE_ST_TAKE: begin
					pc_q <= pc_q + disp_ext + `CBE_PC_STEP;
					st_q <= CBE_ST_IDLE;
				end
				default: begin
					st_q <= CBE_ST_IDLE;
				end
			endcase
		end
	end

	assign hrdata      = hrdata_q;
	assign hreadyout   = 1'b1;
	assign hresp       = `CBE_HRESP_OKAY;
	assign pc_value    = pc_q;
	assign branch_busy = busy;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_launch;
		st_q == CBE_ST_IDLE && wr_cmd;
	endsequence

	sequence s_taken;
		st_q == CBE_ST_EVAL ##1 st_q == CBE_ST_TAKE;
	endsequence

	sequence s_fallthrough;
		st_q == CBE_ST_EVAL ##1 st_q == CBE_ST_IDLE;
	endsequence

	AST_LOWER: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_LOWER
		|=> (st_q == CBE_ST_TAKE) == $past(flags_q.c))
		else $error("lower branch decision does not follow carry");
	AST_MINUS: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_MINUS
		|=> (st_q == CBE_ST_TAKE) == $past(flags_q.n))
		else $error("minus branch decision does not follow negative");
	AST_PLUS: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_PLUS
		|=> (st_q == CBE_ST_TAKE) == !$past(flags_q.n))
		else $error("plus branch decision does not follow negative");
	AST_SGE: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_SGE
		|=> (st_q == CBE_ST_TAKE) == ($past(flags_q.n) == $past(flags_q.v)))
		else $error("signed greater-equal decision wrong");
	AST_SLT: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_SLT
		|=> (st_q == CBE_ST_TAKE) == ($past(flags_q.n) != $past(flags_q.v)))
		else $error("signed less-than decision wrong");
	AST_HSET: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_HSET
		|=> (st_q == CBE_ST_TAKE) == $past(flags_q.h))
		else $error("half-carry-set decision wrong");
	AST_HCLR: assert property (st_q == CBE_ST_EVAL && op_q == CBE_OP_HCLR
		|=> (st_q == CBE_ST_TAKE) == !$past(flags_q.h))
		else $error("half-carry-clear decision wrong");
	AST_TARGET: assert property (s_taken
		|=> pc_q == 16'($past(pc_q, 2) + {{9{disp_q[6]}}, disp_q} + 16'h0001) && taken_q)
		else $error("taken branch target wrong");
	AST_FLAGS_KEPT: assert property (busy && !wr_flags |=> $stable(flags_q))
		else $error("branch altered a status flag");
	AST_CYCLES: assert property (s_launch |=> st_q == CBE_ST_EVAL
		##1 (st_q == CBE_ST_IDLE or (st_q == CBE_ST_TAKE ##1 st_q == CBE_ST_IDLE)))
		else $error("branch did not finish in one or two cycles");
	AST_FALL: assert property (s_fallthrough |-> pc_q == 16'($past(pc_q) + 16'h0001))
		else $error("fall-through did not step the counter by one");

	// launch to idle spans one or two cycles
	AST_BUSY_SPAN: assert property ($rose(busy) |-> ##[1:2] !busy)
		else $error("branch stayed busy too long");
	AST_FALL_CLEAR: assert property (s_fallthrough |-> !taken_q)
		else $error("fall-through left the taken bit set");
	// the counter moves only by a write or a branch
	AST_IDLE_PC: assert property (st_q == CBE_ST_IDLE && !wr_pc |=> pc_q == $past(pc_q))
		else $error("counter moved while idle");

endmodule

`default_nettype wire

// ### test/conditional_branch_eval_test.sv
// Purpose: self-checking bench for the branch evaluator over its AHB-Lite port
// Assumes: zero-wait slave, hready looped back from hreadyout
// Notes: each of the seven branch ops is run with flags that take and flags that fall through; CBE_OP_NONE only falls through
`timescale 1ns/10ps
`default_nettype none
`include "cbe_consts.svh"

module conditional_branch_eval_test
	import cbe_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [15:0] pc_value;
	wire         branch_busy;
	int          failures;
	int          checked;
	logic [31:0] rv;
	logic [7:0]  take_flags [8] = '{8'h01, 8'h04, 8'h29, 8'h0C, 8'h08, 8'h20, 8'h0D, 8'h2D};
	logic [7:0]  fall_flags [8] = '{8'h00, 8'h29, 8'h04, 8'h04, 8'h0C, 8'h0D, 8'h20, 8'h2D};

	cbe_branch_top dut (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hsize       (hsize),
		.hready      (hreadyout),
		.hwdata      (hwdata),
		.hrdata      (hrdata),
		.hreadyout   (hreadyout),
		.hresp       (hresp),
		.pc_value    (pc_value),
		.branch_busy (branch_busy)
	);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic results;
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// one single transfer; entered just after a rising edge
	task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		ahb_xfer(1'b1, a, d, unused);
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		ahb_xfer(1'b0, a, 32'h00000000, d);
	endtask

	task automatic run(input logic [2:0] op, input logic [6:0] k, input logic [7:0] f,
			input logic tk);
		logic [31:0] x;
		logic [15:0] pc_exp;
		int          n;
		reg_wr(`CBE_OFF_PC, 32'h00000100);
		reg_wr(`CBE_OFF_FLAGS, {24'h000000, f});
		reg_wr(`CBE_OFF_CMD, {17'h00000, k, 5'h00, op});
		#1;
		n = 0;
		while (branch_busy === 1'b1 && n < 8) begin
			@(posedge hclk);
			#1;
			n++;
		end
		pc_exp = tk ? 16'h0100 + {{9{k[6]}}, k} + 16'h0001 : 16'h0101;
		check(32'(n), tk ? 32'h00000002 : 32'h00000001);
		check({16'h0000, pc_value}, {16'h0000, pc_exp});
		@(posedge hclk);
		reg_rd(`CBE_OFF_STAT, x);
		check(x, {30'h00000000, tk, 1'b0});
		reg_rd(`CBE_OFF_PC, x);
		check(x, {16'h0000, pc_exp});
		reg_rd(`CBE_OFF_FLAGS, x);
		check(x, {24'h000000, f});
	endtask

	initial begin
		repeat (5000) @(posedge hclk);
		failures++;
		results;
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = `CBE_HSIZE_WORD;
		hwdata = 32'h00000000;
		failures = 0;
		checked = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check({31'h00000000, hresp}, 32'h00000000);
		check({31'h00000000, hreadyout}, 32'h00000001);
		reg_rd(`CBE_OFF_PC, rv);
		check(rv, 32'h00000000);
		reg_rd(`CBE_OFF_FLAGS, rv);
		check(rv, 32'h00000000);
		reg_rd(`CBE_OFF_CMD, rv);
		check(rv, 32'h00000007);
		reg_rd(`CBE_OFF_STAT, rv);
		check(rv, 32'h00000000);
		// unmapped place and a byte-sized write must leave the map alone
		reg_wr(8'h10, 32'hFFFFFFFF);
		reg_rd(8'h10, rv);
		check(rv, 32'h00000000);
		hsize <= 3'h0;
		reg_wr(`CBE_OFF_PC, 32'h00001234);
		hsize <= `CBE_HSIZE_WORD;
		reg_rd(`CBE_OFF_PC, rv);
		check(rv, 32'h00000000);
		// extreme displacements, each of the seven branch ops taken and falling through, CBE_OP_NONE falling through twice
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 2; j++) begin
				run(3'(i), (i % 2 == 1) ? 7'h40 : 7'h3F, (j == 1) ? take_flags[i] : fall_flags[i],
					j == 1 && i != 7);
			end
		end
		results;
	end
endmodule

`default_nettype wire
